/* File: src/smp_pkg.sv */
package smp_pkg;
    localparam int MOD_N  = 6;
    localparam int DATA_W = 64;
    localparam int CODE_W = 8;
    localparam int ADDR_W = 16;

    typedef enum logic [2:0] {
        MOD_INSTR_MEM = 3'h0, MOD_DATA_MEM = 3'h1, MOD_ICACHE = 3'h2,
        MOD_DCACHE    = 3'h3, MOD_TLB      = 3'h4, MOD_CLUSTER = 3'h5
    } smp_mod_t;

    typedef enum logic [3:0] {
        SRC_FETCH   = 4'h0, SRC_LSU     = 4'h1, SRC_FILL  = 4'h2,
        SRC_CCM_ADDR = 4'h3, SRC_CCM_ALL = 4'h4, SRC_INV_ALL = 4'h5,
        SRC_EVICT   = 4'h6, SRC_SLAVE   = 4'h7, SRC_DEBUG = 4'h8,
        SRC_FENCE_ADDR = 4'h9
    } smp_src_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1, ST_ISSUE = 4'h2, ST_CHECK = 4'h4, ST_WRITE = 4'h8
    } smp_fsm_t;

    // csr addresses
    localparam logic [11:0] CSR_INSTR_MEM_CTL = 12'h7c0;
    localparam logic [11:0] CSR_DATA_MEM_CTL  = 12'h7c1;
    localparam logic [11:0] CSR_INJ_CODE      = 12'h7c2;
    localparam logic [11:0] CSR_CACHE_CTL     = 12'h7ca;
    localparam logic [11:0] CSR_TLB_CTL       = 12'h7dd;
    localparam logic [11:0] CSR_LOCK          = 12'h7de;
    localparam logic [11:0] CSR_PROT_CTL      = 12'hbc0;
    localparam logic [11:0] CSR_ERR_STATUS    = 12'hbc4;
    localparam logic [11:0] CSR_ICFG          = 12'hfc0;
    localparam logic [11:0] CSR_DCFG          = 12'hfc1;
    localparam logic [11:0] CSR_CCFG          = 12'hfc2;
    localparam logic [11:0] CSR_TCFG          = 12'hfc3;

    localparam logic [11:0] CTL_ADDR [MOD_N] = '{CSR_INSTR_MEM_CTL,
        CSR_DATA_MEM_CTL, CSR_CACHE_CTL, CSR_CACHE_CTL, CSR_TLB_CTL,
        CSR_PROT_CTL};
    localparam int CTL_LSB [MOD_N] = '{0, 0, 8, 16, 0, 0};

    // control field positions, relative to a module's field group
    localparam int F_EN       = 0;
    localparam int F_EXC      = 1;
    localparam int F_INJ_TAG  = 2;
    localparam int F_INJ_DATA = 3;
    localparam int F_CHK      = 6;
    // injection_code layout, and the CSR_LOCK bit
    localparam int CODE_LSB  = 0;
    localparam int DFLAG_LSB = 16;
    localparam int SFLAG_LSB = 24;
    localparam int LOCK_BIT  = 0;

    localparam logic [31:0] CFG_INFO_VAL = 32'h0000_0001;
    localparam logic [5:0]  SFLAG_MASK   = 6'h1f;
    localparam logic [7:0]  UNIT_NARROW  = 8'h0f;
    localparam logic [7:0]  UNIT_WIDE    = 8'hff;
    localparam logic [63:0] DMASK_NARROW = 64'h0000_0000_ffff_ffff;

    typedef struct packed {
        logic en;
        logic exc;
        logic inj;
        logic chk;
    } smp_ctl_t;
    localparam smp_ctl_t CTL_RST = '{en: 1'b1, exc: 1'b0, inj: 1'b0,
                                     chk: 1'b0};

    typedef struct packed {
        logic        valid;
        logic        we;
        logic        mmode;
        logic [11:0] addr;
        logic [31:0] wdata;
    } smp_csr_req_t;

    typedef struct packed {
        logic              valid;
        logic              we;
        smp_src_t          src;
        smp_mod_t          mod;
        logic              way_derr;
        logic [7:0]        bmask;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } smp_acc_req_t;

    typedef struct packed {
        logic              en;
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [CODE_W-1:0] code;
    } smp_ram_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [CODE_W-1:0] code;
    } smp_ram_rsp_t;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] rdata;
        logic              sbe;
        logic              dbe;
        logic              bus_err;
        logic              exc_precise;
        logic              exc_imprecise;
        logic              store_fault;
        logic              tval_clear;
    } smp_resp_t;

    typedef struct packed {
        smp_fsm_t                fsm;
        smp_acc_req_t            req;
        smp_ctl_t [MOD_N-1:0]    ctl;
        logic [CODE_W-1:0]       code;
        logic [MOD_N-1:0]        dflags;
        logic [MOD_N-1:0]        sflags;
        logic [MOD_N-1:0]        status;
        logic                    lock;
        logic [31:0]             csr_rdata;
        smp_resp_t               resp;
        smp_ram_req_t            ram;
        logic [MOD_N-1:0]        err_s;
        logic [MOD_N-1:0]        err_d;
    } smp_state_t;
endpackage

/* File: src/smp_protection.sv */
`timescale 1ns/1ns
`default_nettype none
module smp_protection (
    // clock and reset
    input  wire logic                  i_core_clk,
    input  wire logic                  i_resetn,
    // csr port
    input  wire smp_pkg::smp_csr_req_t i_csr,
    output logic [31:0]                o_csr_rdata,
    // core access to protected arrays
    input  wire smp_pkg::smp_acc_req_t i_acc,
    output logic                       o_acc_ready,
    output smp_pkg::smp_resp_t         o_resp,
    // sram array
    output smp_pkg::smp_ram_req_t      o_ram,
    input  wire smp_pkg::smp_ram_rsp_t i_ram_rsp,
    // soc error indications
    output logic [5:0]                 o_err_single,
    output logic [5:0]                 o_err_double
);
    logic [1:0]                 rst_q;
    logic                       rst_n;
    smp_pkg::smp_state_t        st_reg;
    smp_pkg::smp_state_t        st_next;
    smp_pkg::smp_ctl_t          ctl_q;
    logic [6:0]                 syn;
    logic                       ovr;
    logic                       chk_on;
    logic                       sbe;
    logic                       dbe;
    logic [63:0]                corr;
    logic [63:0]                merged;
    logic [7:0]                 um;
    logic                       full_in;
    logic                       inj_in;
    logic [63:0]                acc_data;
    logic [7:0]                 acc_code;
    logic [7:0]                 rmw_code;
    logic                       csr_wr;
    logic [31:0]                rd;
    logic [5:0]                 ev_s;
    logic [5:0]                 ev_d;

    function automatic logic [6:0] ham(input logic [63:0] d);
        logic [6:0] p;
        logic [7:0] pos;
        p = 7'h0;
        pos = 8'h3;
        for (int i = 0; i < smp_pkg::DATA_W; i++) begin
            if ((pos & (pos - 8'h1)) == 8'h0) pos = pos + 8'h1;
            if (d[i]) p = p ^ pos[6:0];
            pos = pos + 8'h1;
        end
        return p;
    endfunction

    function automatic logic [7:0] enc(input logic [63:0] d);
        logic [6:0] h;
        h = ham(d);
        return {^{d, h}, h};
    endfunction

    // flips the data bit whose hamming position equals the syndrome
    function automatic logic [63:0] fix(input logic [63:0] d,
                                        input logic [6:0]  s);
        logic [63:0] r;
        logic [7:0]  pos;
        r = d;
        pos = 8'h3;
        for (int i = 0; i < smp_pkg::DATA_W; i++) begin
            if ((pos & (pos - 8'h1)) == 8'h0) pos = pos + 8'h1;
            if (pos[6:0] == s) r[i] = ~d[i];
            pos = pos + 8'h1;
        end
        return r;
    endfunction

    function automatic logic narrow(input smp_pkg::smp_mod_t m);
        return m == smp_pkg::MOD_DATA_MEM || m == smp_pkg::MOD_DCACHE;
    endfunction

    function automatic logic [63:0] dmask(input smp_pkg::smp_mod_t m);
        return narrow(m) ? smp_pkg::DMASK_NARROW : '1;
    endfunction

    function automatic logic inj_ok(input smp_pkg::smp_ctl_t c,
                                    input smp_pkg::smp_src_t s,
                                    input smp_pkg::smp_mod_t m);
        return c.inj && (s == smp_pkg::SRC_FILL ||
            (s == smp_pkg::SRC_LSU && (m == smp_pkg::MOD_INSTR_MEM ||
                                       m == smp_pkg::MOD_DATA_MEM)));
    endfunction

    function automatic logic [31:0] ctl_img(input smp_pkg::smp_ctl_t c);
        logic [31:0] r;
        r = 32'h0;
        r[smp_pkg::F_EN] = c.en;
        r[smp_pkg::F_EXC] = c.exc;
        r[smp_pkg::F_INJ_TAG] = c.inj;
        r[smp_pkg::F_INJ_DATA] = c.inj;
        r[smp_pkg::F_CHK] = c.chk;
        return r;
    endfunction

    function automatic smp_pkg::smp_ctl_t ctl_parse(input logic [31:0] w);
        smp_pkg::smp_ctl_t c;
        c.en = w[smp_pkg::F_EN];
        c.exc = w[smp_pkg::F_EXC];
        c.inj = w[smp_pkg::F_INJ_TAG] | w[smp_pkg::F_INJ_DATA];
        c.chk = w[smp_pkg::F_CHK];
        return c;
    endfunction

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    // decode of the word returned by the array
    assign ctl_q = st_reg.ctl[st_reg.req.mod];
    assign chk_on = ctl_q.en & ctl_q.chk;
    assign syn = ham(i_ram_rsp.data) ^ i_ram_rsp.code[6:0];
    assign ovr = ^{i_ram_rsp.data, i_ram_rsp.code};
    assign sbe = chk_on & ovr;
    assign dbe = chk_on & ((!ovr && syn != 7'h0) | st_reg.req.way_derr);
    assign corr = (sbe ? fix(i_ram_rsp.data, syn) : i_ram_rsp.data)
                  & dmask(st_reg.req.mod);

    genvar b;
    generate
        for (b = 0; b < smp_pkg::DATA_W / 8; b++) begin : g_merge
            assign merged[b*8 +: 8] = st_reg.req.bmask[b] ?
                st_reg.req.wdata[b*8 +: 8] : corr[b*8 +: 8];
        end
    endgenerate

    assign um = narrow(i_acc.mod) ? smp_pkg::UNIT_NARROW
                                  : smp_pkg::UNIT_WIDE;
    assign full_in = i_acc.mod == smp_pkg::MOD_TLB || (i_acc.bmask & um) == um;
    assign inj_in = inj_ok(st_reg.ctl[i_acc.mod], i_acc.src, i_acc.mod);
    assign acc_data = i_acc.wdata & dmask(i_acc.mod);
    assign acc_code = inj_in ? st_reg.code : enc(acc_data);
    assign rmw_code = inj_ok(ctl_q, st_reg.req.src, st_reg.req.mod) ?
        st_reg.code : enc(merged & dmask(st_reg.req.mod));
    assign csr_wr = i_csr.valid & i_csr.we & i_csr.mmode & !st_reg.lock;

    always_comb begin
        rd = 32'h0;
        for (int m = 0; m < smp_pkg::MOD_N; m++) begin
            if (i_csr.addr == smp_pkg::CTL_ADDR[m])
                rd = rd | (ctl_img(st_reg.ctl[m]) << smp_pkg::CTL_LSB[m]);
        end
        case (i_csr.addr)
            smp_pkg::CSR_INJ_CODE: begin
                rd[smp_pkg::CODE_LSB +: smp_pkg::CODE_W] = st_reg.code;
                rd[smp_pkg::DFLAG_LSB +: smp_pkg::MOD_N] = st_reg.dflags;
                rd[smp_pkg::SFLAG_LSB +: smp_pkg::MOD_N] = st_reg.sflags;
            end
            smp_pkg::CSR_ERR_STATUS: rd[smp_pkg::MOD_N-1:0] = st_reg.status;
            smp_pkg::CSR_LOCK:       rd[smp_pkg::LOCK_BIT] = st_reg.lock;
            smp_pkg::CSR_ICFG, smp_pkg::CSR_DCFG, smp_pkg::CSR_CCFG,
            smp_pkg::CSR_TCFG:       rd = smp_pkg::CFG_INFO_VAL;
            default:                 rd = rd;
        endcase
    end

    always_comb begin
        st_next = st_reg;
        st_next.resp = '0;
        st_next.ram.en = 1'b0;
        st_next.ram.we = 1'b0;
        st_next.err_s = 6'h0;
        st_next.err_d = 6'h0;
        ev_s = 6'h0;
        ev_d = 6'h0;
        st_next.csr_rdata = (i_csr.valid & i_csr.mmode) ? rd : 32'h0;
        for (int m = 0; m < smp_pkg::MOD_N; m++) begin
            if (csr_wr && i_csr.addr == smp_pkg::CTL_ADDR[m])
                st_next.ctl[m] =
                    ctl_parse(i_csr.wdata >> smp_pkg::CTL_LSB[m]);
        end
        if (csr_wr && i_csr.addr == smp_pkg::CSR_INJ_CODE) begin
            st_next.code = i_csr.wdata[smp_pkg::CODE_LSB +: smp_pkg::CODE_W];
            st_next.dflags = i_csr.wdata[smp_pkg::DFLAG_LSB +: smp_pkg::MOD_N];
            st_next.sflags = i_csr.wdata[smp_pkg::SFLAG_LSB +: smp_pkg::MOD_N];
        end
        if (csr_wr && i_csr.addr == smp_pkg::CSR_ERR_STATUS) begin
            st_next.status = i_csr.wdata[smp_pkg::MOD_N-1:0];
            st_next.err_d = i_csr.wdata[smp_pkg::MOD_N-1:0];
        end
        if (i_csr.valid && i_csr.we && i_csr.mmode &&
            i_csr.addr == smp_pkg::CSR_LOCK && i_csr.wdata[smp_pkg::LOCK_BIT])
            st_next.lock = 1'b1;

        case (st_reg.fsm)
            smp_pkg::ST_IDLE: begin
                if (i_acc.valid) begin
                    st_next.req = i_acc;
                    if (i_acc.src == smp_pkg::SRC_INV_ALL) begin
                        st_next.resp.valid = 1'b1;
                    end else if (i_acc.we && full_in) begin
                        st_next.ram = '{en: 1'b1, we: 1'b1, addr: i_acc.addr,
                            wdata: acc_data, code: acc_code};
                        st_next.fsm = smp_pkg::ST_WRITE;
                    end else begin
                        st_next.ram.en = 1'b1;
                        st_next.ram.addr = i_acc.addr;
                        st_next.fsm = smp_pkg::ST_ISSUE;
                    end
                end
            end
            smp_pkg::ST_ISSUE: st_next.fsm = smp_pkg::ST_CHECK;
            smp_pkg::ST_CHECK: begin
                st_next.fsm = smp_pkg::ST_IDLE;
                st_next.resp.valid = 1'b1;
                if (dbe) begin
                    ev_d[st_reg.req.mod] = 1'b1;
                    st_next.resp.dbe = 1'b1;
                    case (st_reg.req.src)
                        smp_pkg::SRC_FETCH:
                            st_next.resp.exc_precise = ctl_q.exc;
                        smp_pkg::SRC_LSU, smp_pkg::SRC_EVICT:
                            st_next.resp.exc_imprecise = ctl_q.exc;
                        smp_pkg::SRC_CCM_ADDR, smp_pkg::SRC_CCM_ALL,
                        smp_pkg::SRC_FENCE_ADDR: begin
                            st_next.resp.store_fault = ctl_q.exc;
                            st_next.resp.tval_clear = ctl_q.exc;
                        end
                        smp_pkg::SRC_SLAVE, smp_pkg::SRC_DEBUG:
                            st_next.resp.bus_err = 1'b1;
                        default: st_next.resp.bus_err = 1'b0;
                    endcase
                end else begin
                    ev_s[st_reg.req.mod] = sbe;
                    st_next.resp.sbe = sbe;
                    st_next.resp.rdata = corr;
                    if (st_reg.req.we) begin
                        st_next.resp.valid = 1'b0;
                        st_next.ram = '{en: 1'b1, we: 1'b1,
                            addr: st_reg.req.addr,
                            wdata: merged & dmask(st_reg.req.mod),
                            code: rmw_code};
                        st_next.fsm = smp_pkg::ST_WRITE;
                    end else if (sbe) begin
                        st_next.ram = '{en: 1'b1, we: 1'b1,
                            addr: st_reg.req.addr, wdata: corr,
                            code: enc(corr)};
                        st_next.fsm = smp_pkg::ST_WRITE;
                    end
                end
            end
            smp_pkg::ST_WRITE: begin
                st_next.fsm = smp_pkg::ST_IDLE;
                st_next.resp.valid = st_reg.req.we;
            end
            default: st_next.fsm = smp_pkg::ST_IDLE;
        endcase

        // hardware events win over a same-cycle software clear, except MOD_CLUSTER single errors, which never set sflags
        st_next.dflags = st_next.dflags | ev_d;
        st_next.sflags = st_next.sflags | (ev_s & smp_pkg::SFLAG_MASK);
        st_next.status = st_next.status | ev_d;
        st_next.err_s = ev_s;
        st_next.err_d = st_next.err_d | ev_d;
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.fsm <= smp_pkg::ST_IDLE;
            st_reg.ctl <= {smp_pkg::MOD_N{smp_pkg::CTL_RST}};
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_csr_rdata = st_reg.csr_rdata;
    assign o_acc_ready = st_reg.fsm == smp_pkg::ST_IDLE;
    assign o_resp = st_reg.resp;
    assign o_ram = st_reg.ram;
    assign o_err_single = st_reg.err_s;
    assign o_err_double = st_reg.err_d;

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!rst_n);

    chk_reset_enables: assert property ($rose(rst_n) |->
        st_reg.ctl == {smp_pkg::MOD_N{smp_pkg::CTL_RST}})
        else $error("enables wrong after reset");
    chk_lock_sticky: assert property (st_reg.lock |=> st_reg.lock)
        else $error("lock dropped");
    chk_lock_freeze: assert property (st_reg.lock |=>
        $stable(st_reg.ctl) && $stable(st_reg.code))
        else $error("locked register changed");
    chk_full_write: assert property (o_acc_ready && i_acc.valid && i_acc.we
        && full_in && i_acc.src != smp_pkg::SRC_INV_ALL |=>
        o_ram.en && o_ram.we && o_ram.code == $past(acc_code))
        else $error("full write not stored with code");
    chk_partial_rmw: assert property (o_acc_ready && i_acc.valid && i_acc.we
        && !full_in |=> (o_ram.en && !o_ram.we) ##2
        ((o_ram.en && o_ram.we) || o_resp.dbe))
        else $error("narrow write skipped read-modify-write");
    chk_scrub_write: assert property (st_reg.fsm == smp_pkg::ST_CHECK && sbe
        && !dbe && !st_reg.req.we |=> o_ram.we && o_resp.valid
        && o_ram.wdata == $past(corr) && !o_resp.exc_precise)
        else $error("single error not scrubbed");
    chk_trap_gate: assert property (o_resp.valid && !ctl_q.exc |->
        !o_resp.exc_precise && !o_resp.exc_imprecise && !o_resp.store_fault)
        else $error("trap without trap enable");
    chk_fetch_precise: assert property (o_resp.dbe && ctl_q.exc &&
        st_reg.req.src == smp_pkg::SRC_FETCH |->
        o_resp.exc_precise && !o_resp.exc_imprecise)
        else $error("fetch double error not precise");
    chk_bus_error: assert property (o_resp.dbe && (st_reg.req.src ==
        smp_pkg::SRC_SLAVE || st_reg.req.src == smp_pkg::SRC_DEBUG) |->
        o_resp.bus_err && !o_resp.exc_imprecise && !o_resp.exc_precise)
        else $error("slave double error not bus error");
    chk_dflag_set: assert property (o_resp.dbe |->
        st_reg.dflags[st_reg.req.mod] && o_err_double[st_reg.req.mod])
        else $error("double error flag missing");
    chk_inv_all: assert property (o_acc_ready && i_acc.valid &&
        i_acc.src == smp_pkg::SRC_INV_ALL |=>
        o_resp.valid && !o_resp.dbe && !o_ram.en)
        else $error("invalidate-all was checked");

    cov_scrub: cover property (st_reg.fsm == smp_pkg::ST_CHECK && sbe);
    cov_dbe_trap: cover property (o_resp.dbe && o_resp.exc_imprecise);
    cov_rmw: cover property (o_ram.we && st_reg.fsm == smp_pkg::ST_WRITE
        && st_reg.req.we && !(&st_reg.req.bmask));
endmodule
`default_nettype wire

/* File: bench/smp_sram_model.sv */
`timescale 1ns/1ns
`default_nettype none
module smp_sram_model (
    // clock
    input  wire logic                  i_clk,
    // array port
    input  wire smp_pkg::smp_ram_req_t i_ram,
    input  wire logic [63:0]           i_flip,
    output var  smp_pkg::smp_ram_rsp_t o_rsp
);
    smp_pkg::smp_ram_rsp_t mem [logic [15:0]];
    initial o_rsp = '0;
    always @(posedge i_clk) begin
        if (i_ram.en && i_ram.we) begin
            mem[i_ram.addr] = '{data: i_ram.wdata, code: i_ram.code};
        end
        if (i_ram.en && !i_ram.we && mem.exists(i_ram.addr)) begin
            // upset sticks in the array until rewritten
            mem[i_ram.addr].data = mem[i_ram.addr].data ^ i_flip;
            o_rsp <= mem[i_ram.addr];
        end else begin
            // released lines show the inverse of the last value
            o_rsp <= ~o_rsp;
        end
    end
endmodule
`default_nettype wire

/* File: bench/tb_smp_protection.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_smp_protection;
    logic                  clk     = 1'b0;
    logic                  rstn    = 1'b0;
    smp_pkg::smp_csr_req_t csr     = '0;
    smp_pkg::smp_acc_req_t acc     = '0;
    logic [63:0]           flip    = '0;
    logic [31:0]           csr_rd;
    logic [31:0]           rd;
    logic                  ready;
    smp_pkg::smp_resp_t    resp;
    smp_pkg::smp_resp_t    last;
    smp_pkg::smp_ram_req_t ram;
    smp_pkg::smp_ram_rsp_t ram_rsp;
    logic [5:0]            es;
    logic [5:0]            ed;
    logic [5:0]            last_es;
    logic [5:0]            last_ed;
    logic                  wd      = 1'b0;
    int                    n_fail  = 0;
    int                    compares = 0;
    int                    cyc     = 0;
    localparam logic [63:0] D1 = 64'h0123_4567_89ab_cdef;
    localparam logic [63:0] D2 = 64'hfedc_ba98_7654_3210;

    always #25 clk = ~clk;

    smp_protection dut (.i_core_clk(clk), .i_resetn(rstn), .i_csr(csr),
        .o_csr_rdata(csr_rd), .i_acc(acc), .o_acc_ready(ready),
        .o_resp(resp), .o_ram(ram), .i_ram_rsp(ram_rsp),
        .o_err_single(es), .o_err_double(ed));
    smp_sram_model sram (.i_clk(clk), .i_ram(ram), .i_flip(flip),
        .o_rsp(ram_rsp));

    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic cmp_w(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: word %h expected %h", $time, got, exp);
        end
    endtask

    // flags order: single, double, bus error, precise, imprecise,
    // store fault, trap value clear
    task automatic cmp_f(input logic [6:0] exp);
        compares++;
        if ({last.sbe, last.dbe, last.bus_err, last.exc_precise,
             last.exc_imprecise, last.store_fault, last.tval_clear} !== exp
            || last.valid !== 1'b1) begin
            n_fail++;
            $display("mismatch at %0t: flags, expected %b", $time, exp);
        end
    endtask

    task automatic csr_op(input logic we, input logic [11:0] a,
                          input logic [31:0] d);
        @(posedge clk);
        csr <= '{valid: 1'b1, we: we, mmode: 1'b1, addr: a, wdata: d};
        @(posedge clk);
        csr.valid <= 1'b0;
        @(negedge clk);
        rd = csr_rd;
    endtask

    task automatic acc_op(input smp_pkg::smp_src_t s,
        input smp_pkg::smp_mod_t m, input logic we, input logic [7:0] bm,
        input logic [15:0] a, input logic [63:0] d, input logic [63:0] f);
        int n;
        n = 0;
        @(posedge clk);
        flip <= f;
        acc <= '{valid: 1'b1, we: we, src: s, mod: m, way_derr: wd,
                 bmask: bm, addr: a, wdata: d};
        @(negedge clk);
        while (ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        acc.valid <= 1'b0;
        do begin
            @(negedge clk);
            n++;
        end while (resp.valid !== 1'b1 && n < 20);
        last = resp;
        last_es = es;
        last_ed = ed;
        flip <= '0;
        while (ready !== 1'b1) @(negedge clk);
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            end_sim();
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        csr_op(0, smp_pkg::CSR_INSTR_MEM_CTL, '0);
        cmp_w(rd, 1);
        csr_op(0, smp_pkg::CSR_CACHE_CTL, '0);
        cmp_w(rd, 32'h101_00);
        csr_op(0, smp_pkg::CSR_TLB_CTL, '0);
        cmp_w(rd, 1);
        csr_op(0, smp_pkg::CSR_PROT_CTL, '0);
        cmp_w(rd, 1);
        csr_op(0, 12'h7c3, '0);
        cmp_w(rd, 0);
        $display("test reset image done");
        csr_op(1, smp_pkg::CSR_INSTR_MEM_CTL, 32'h43);
        acc_op(smp_pkg::SRC_LSU, smp_pkg::MOD_INSTR_MEM, 1, 8'hff, 16, D1, 0);
        acc_op(smp_pkg::SRC_LSU, smp_pkg::MOD_INSTR_MEM, 0, 8'hff, 16, 0, 0);
        cmp_w(last.rdata, D1);
        acc_op(smp_pkg::SRC_LSU, smp_pkg::MOD_INSTR_MEM, 0, 8'hff, 16, 0, 32);
        cmp_w(last.rdata, D1);
        cmp_f(7'b1000000);
        cmp_w(last_es, 6'h01);
        acc_op(smp_pkg::SRC_LSU, smp_pkg::MOD_INSTR_MEM, 0, 8'hff, 16, 0, 0);
        cmp_f(7'b0000000);
        csr_op(0, smp_pkg::CSR_INJ_CODE, '0);
        cmp_w(rd, 32'h100_0000);
        $display("test single error done");
        acc_op(smp_pkg::SRC_LSU, smp_pkg::MOD_INSTR_MEM, 0, 8'hff, 16, 0, 3);
        cmp_f(7'b0100100);
        cmp_w(last_ed, 6'h01);
        acc_op(smp_pkg::SRC_FETCH, smp_pkg::MOD_INSTR_MEM, 0, 8'hff, 16, 0, 0);
        cmp_f(7'b0101000);
        acc_op(smp_pkg::SRC_SLAVE, smp_pkg::MOD_INSTR_MEM, 0, 8'hff, 16, 0, 0);
        cmp_f(7'b0110000);
        csr_op(0, smp_pkg::CSR_INJ_CODE, '0);
        cmp_w(rd, 32'h101_0000);
        csr_op(1, smp_pkg::CSR_INSTR_MEM_CTL, 32'h41);
        acc_op(smp_pkg::SRC_LSU, smp_pkg::MOD_INSTR_MEM, 0, 8'hff, 16, 0, 0);
        cmp_f(7'b0100000);
        $display("test double error done");
        acc_op(smp_pkg::SRC_LSU, smp_pkg::MOD_INSTR_MEM, 1, 8'hff, 32, D2, 0);
        acc_op(smp_pkg::SRC_LSU, smp_pkg::MOD_INSTR_MEM, 1, 8'h01, 32, 'haa, 0);
        acc_op(smp_pkg::SRC_LSU, smp_pkg::MOD_INSTR_MEM, 0, 8'hff, 32, 0, 0);
        cmp_w(last.rdata, {D2[63:8], 8'haa});
        acc_op(smp_pkg::SRC_LSU, smp_pkg::MOD_DATA_MEM, 1, 8'h0f, 8, D1, 0);
        acc_op(smp_pkg::SRC_LSU, smp_pkg::MOD_DATA_MEM, 0, 8'h0f, 8, 0, 0);
        cmp_w(last.rdata, {32'h0, D1[31:0]});
        $display("test write paths done");
        // code 3 over a zero word reads back as a double error
        csr_op(1, smp_pkg::CSR_INJ_CODE, 32'h3);
        csr_op(1, smp_pkg::CSR_INSTR_MEM_CTL, 32'h47);
        acc_op(smp_pkg::SRC_LSU, smp_pkg::MOD_INSTR_MEM, 1, 8'hff, 48, 0, 0);
        csr_op(1, smp_pkg::CSR_INSTR_MEM_CTL, 32'h43);
        acc_op(smp_pkg::SRC_LSU, smp_pkg::MOD_INSTR_MEM, 0, 8'hff, 48, 0, 0);
        cmp_f(7'b0100100);
        wd = 1'b1;
        acc_op(smp_pkg::SRC_FETCH, smp_pkg::MOD_INSTR_MEM, 0, 8'hff, 32, 0, 0);
        cmp_f(7'b0101000);
        wd = 1'b0;
        csr_op(1, smp_pkg::CSR_TLB_CTL, 32'h43);
        acc_op(smp_pkg::SRC_FENCE_ADDR, smp_pkg::MOD_TLB, 0, 8'hff, 48, 0, 0);
        cmp_f(7'b0100011);
        cmp_w(last_ed, 6'h10);
        // protection set before any cache use, never changed after
        csr_op(1, smp_pkg::CSR_CACHE_CTL, 32'h0043_4300);
        acc_op(smp_pkg::SRC_CCM_ADDR, smp_pkg::MOD_ICACHE, 0, 8'hff, 48, 0, 0);
        cmp_f(7'b0100011);
        acc_op(smp_pkg::SRC_CCM_ALL, smp_pkg::MOD_DCACHE, 0, 8'hff, 48, 0, 0);
        cmp_f(7'b0100011);
        acc_op(smp_pkg::SRC_EVICT, smp_pkg::MOD_DCACHE, 0, 8'hff, 48, 0, 0);
        cmp_f(7'b0100100);
        cmp_w(last_ed, 6'h08);
        acc_op(smp_pkg::SRC_INV_ALL, smp_pkg::MOD_ICACHE, 0, 8'hff, 48, 0, 0);
        cmp_f(7'b0000000);
        $display("test fault routes done");
        csr_op(1, smp_pkg::CSR_LOCK, 32'h1);
        csr_op(1, smp_pkg::CSR_INSTR_MEM_CTL, 32'h0);
        csr_op(0, smp_pkg::CSR_INSTR_MEM_CTL, '0);
        cmp_w(rd, 32'h43);
        csr_op(1, smp_pkg::CSR_LOCK, 32'h0);
        csr_op(0, smp_pkg::CSR_LOCK, '0);
        cmp_w(rd, 1);
        $display("test lock done");
        end_sim();
    end
endmodule
`default_nettype wire
